// File: pkg/sfe_pkg.sv
// Shared constants for the serial flash erase and power-down handler.
// Assumes a 100 MHz core clock and a host that frames commands with chip select.
package sfe_pkg;

  // Core clock
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Command opcodes
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE   = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_DEEP_SLEEP   = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID      = 8'hAB;
  localparam logic [7:0] OP_WRITE_ARM    = 8'h06;
  localparam logic [7:0] OP_QUAD_ENTER   = 8'h38;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_READ_SUSPEND = 8'h09;
  // Software reset opcode; value is arbitrary
  localparam logic [7:0] OP_SOFT_RESET   = 8'h99;

  // Frame lengths in clock edges (opcode only, opcode plus 24-bit address)
  localparam logic [5:0] LEN_OP_SINGLE  = 6'h08;
  localparam logic [5:0] LEN_CMD_SINGLE = 6'h20;
  localparam logic [5:0] LEN_OP_QUAD    = 6'h02;
  localparam logic [5:0] LEN_CMD_QUAD   = 6'h08;
  localparam logic [5:0] EDGE_CAP       = 6'h3F;

  // Status byte bit positions
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned SU_PSUS_BIT  = 2;
  localparam int unsigned SU_ESUS_BIT  = 3;

  // Single-bit mode output lane
  localparam int unsigned SO_LANE = 1;

  // Erase kinds as seen on the erase_kind port
  localparam logic [1:0] KIND_SECTOR = 2'h0;
  localparam logic [1:0] KIND_HALF   = 2'h1;
  localparam logic [1:0] KIND_BLOCK  = 2'h2;
  localparam logic [1:0] KIND_CHIP   = 2'h3;

  // Address alignment masks per erase unit
  localparam logic [23:0] MASK_SECTOR = 24'hFFF000;
  localparam logic [23:0] MASK_HALF   = 24'hFF8000;
  localparam logic [23:0] MASK_BLOCK  = 24'hFF0000;
  localparam logic [23:0] MASK_CHIP   = 24'h000000;

  // One-time-programmable sector number (address bits 23:12)
  localparam logic [11:0] OTP_SECTOR = 12'h7FF;

  // Self-timed durations in microseconds (plain defaults)
  localparam int unsigned SECTOR_ERASE_TIME_US = 1000;
  localparam int unsigned HALF_ERASE_TIME_US   = 2000;
  localparam int unsigned BLOCK_ERASE_TIME_US  = 3000;
  localparam int unsigned CHIP_ERASE_TIME_US   = 10000;

  // Power-down entry delay, least time rounded up to whole cycles
  localparam int unsigned SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int unsigned SLEEP_ENTRY_CYCLES   =
    (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Core sequencer states
  typedef enum logic [1:0] {
    SFE_IDLE,
    SFE_CHECK,
    SFE_ERASE,
    SFE_SLEEP_WAIT
  } sfe_state_t;

endpackage

// File: pkg/sfe_link_if.sv
// Carrier between the serial front end and the core sequencer.
// Link-side words are stable while chip select is high; core-side words
// only change while the device is deselected.
`timescale 1ns/1ps
`default_nettype none
interface sfe_link_if;
  logic [31:0] sh1;       // Single-lane shift history
  logic [31:0] sh4;       // Four-lane shift history
  logic [5:0]  edges;     // Rising edges seen this frame
  logic [7:0]  stat_byte; // Frozen ordinary status
  logic [7:0]  susp_byte; // Frozen suspend status
  logic        quad;      // Four-lane mode
  logic        asleep;    // Deep power-down snapshot

  modport link (output sh1, sh4, edges, input stat_byte, susp_byte, quad, asleep);
  modport core (input sh1, sh4, edges, output stat_byte, susp_byte, quad, asleep);
endinterface
`default_nettype wire

// File: logic/sfe_link_rx.sv
// Serial front end on the host's clock: shifts in command bits, answers
// status reads. Assumes chip select high ends a frame and that the
// core words in the carrier are steady while chip select is low.
`timescale 1ns/1ps
`default_nettype none
module sfe_link_rx (
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] dq_i,
  output logic      [3:0] dq_o,
  output logic      [3:0] dq_oe,
  // Core side
  sfe_link_if.link        lnk
);

  logic [31:0] sh1_q;
  logic [31:0] sh4_q;
  logic [5:0]  edges_q;
  logic [7:0]  out_q;
  logic        reading_q;
  logic [3:0]  dq_o_q;
  logic [3:0]  dq_oe_q;
  logic [7:0]  op_now;
  logic        op_edge;
  logic        fresh_q;

  // Opcode as completed by the current rising edge
  always_comb begin
    op_now  = lnk.quad ? {sh4_q[3:0], dq_i} : {sh1_q[6:0], dq_i[0]};
    op_edge = !fresh_q &&
              (lnk.quad ? (edges_q == sfe_pkg::LEN_OP_QUAD - 6'h01)
                        : (edges_q == sfe_pkg::LEN_OP_SINGLE - 6'h01));
  end

  // Frame start marker: set while deselected, dropped by the first edge
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Input shifting, MSB first on rising edges; the first edge of a frame
  // restarts it, so the last frame stays readable by the core after deselect
  always_ff @(posedge sclk) begin
    if (fresh_q) begin
      sh1_q   <= {31'h00000000, dq_i[0]};
      sh4_q   <= {28'h0000000, dq_i};
      edges_q <= 6'h01;
    end else begin
      sh1_q <= {sh1_q[30:0], dq_i[0]};
      sh4_q <= {sh4_q[27:0], dq_i};
      if (edges_q != sfe_pkg::EDGE_CAP) begin
        edges_q <= edges_q + 6'h01;
      end
    end
  end

  // Status read engine; ignored while asleep
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      reading_q <= 1'b0;
      out_q     <= 8'h00;
    end else if (op_edge && !lnk.asleep &&
                 (op_now == sfe_pkg::OP_READ_STATUS ||
                  op_now == sfe_pkg::OP_READ_SUSPEND)) begin
      reading_q <= 1'b1;
      out_q     <= (op_now == sfe_pkg::OP_READ_SUSPEND) ? lnk.susp_byte
                                                         : lnk.stat_byte;
    end else if (reading_q) begin
      // Rotate so the byte repeats for as long as the host clocks
      out_q <= lnk.quad ? {out_q[3:0], out_q[7:4]} : {out_q[6:0], out_q[7]};
    end
  end

  // Output lanes change on falling edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      dq_o_q  <= 4'h0;
      dq_oe_q <= 4'h0;
    end else if (reading_q && lnk.quad) begin
      dq_o_q  <= out_q[7:4];
      dq_oe_q <= 4'hF;
    end else if (reading_q) begin
      dq_o_q                  <= 4'h0;
      dq_o_q[sfe_pkg::SO_LANE] <= out_q[7];
      dq_oe_q                 <= 4'h0;
      dq_oe_q[sfe_pkg::SO_LANE] <= 1'b1;
    end
  end

  assign dq_o      = dq_o_q;
  assign dq_oe     = dq_oe_q;
  assign lnk.sh1   = sh1_q;
  assign lnk.sh4   = sh4_q;
  assign lnk.edges = edges_q;

endmodule
`default_nettype wire

// File: logic/sfe_core.sv
// Erase and deep power-down command handler of a serial flash device.
// Assumes the host holds chip select high during reset and for at least
// three core clocks between frames, and keeps 30 ns from select to clock.
`timescale 1ns/1ps
`default_nettype none
module sfe_core #(
  parameter int unsigned SECTOR_ERASE_CYCLES =
    sfe_pkg::SECTOR_ERASE_TIME_US * sfe_pkg::CLK_MHZ,
  parameter int unsigned HALF_ERASE_CYCLES =
    sfe_pkg::HALF_ERASE_TIME_US * sfe_pkg::CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYCLES =
    sfe_pkg::BLOCK_ERASE_TIME_US * sfe_pkg::CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYCLES =
    sfe_pkg::CHIP_ERASE_TIME_US * sfe_pkg::CLK_MHZ
) (
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  dq_i,
  output logic      [3:0]  dq_o,
  output logic      [3:0]  dq_oe,
  // Protection and mode inputs
  input  wire logic [3:0]  protect_bits,
  input  wire logic        block_lock_enable,
  input  wire logic        otp_mode,
  input  wire logic        region_locked,
  input  wire logic        program_suspended_flag,
  input  wire logic        erase_suspended_flag,
  // Status outputs
  output logic             busy_flag,
  output logic             write_latch_flag,
  output logic             deep_sleep,
  output logic             quad_mode,
  output logic             standby,
  // Array erase command
  output logic             erase_start,
  output logic      [1:0]  erase_kind,
  output logic      [23:0] erase_base
);

  sfe_link_if lnk ();

  sfe_pkg::sfe_state_t state_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        latch_q;
  logic        quad_q;
  logic        sleep_q;
  logic        standby_q;
  logic        start_q;
  logic [1:0]  kind_q;
  logic [23:0] base_q;
  logic [31:0] cnt_q;
  logic [7:0]  stat_hold_q;
  logic [7:0]  susp_hold_q;
  logic        sleep_hold_q;

  logic        cs_rise;
  logic [31:0] frame_data;
  logic        is_short;
  logic        is_long;
  logic [7:0]  op_short;
  logic [7:0]  op_long;
  logic [23:0] addr;
  logic        can_cmd;
  logic        area_req;
  logic        chip_req;
  logic        chip_ok;
  logic        sleep_req;
  logic        wake_req;
  logic        reset_req;
  logic        arm_req;
  logic        quad_req;
  logic [1:0]  area_kind;
  logic [23:0] area_mask;
  logic        check_ok;
  logic [31:0] erase_len;

  // Serial front end on the host clock
  sfe_link_rx u_link (
    .sclk  (sclk),
    .cs_n  (cs_n),
    .dq_i  (dq_i),
    .dq_o  (dq_o),
    .dq_oe (dq_oe),
    .lnk   (lnk)
  );

  // Chip select synchroniser and deselect edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  assign cs_rise = cs_s2_q && !cs_s3_q;

  // Frame decode; link words are steady once deselect is seen
  always_comb begin
    frame_data = quad_q ? lnk.sh4 : lnk.sh1;
    is_short   = cs_rise && (lnk.edges == (quad_q ? sfe_pkg::LEN_OP_QUAD
                                                   : sfe_pkg::LEN_OP_SINGLE));
    is_long    = cs_rise && (lnk.edges == (quad_q ? sfe_pkg::LEN_CMD_QUAD
                                                   : sfe_pkg::LEN_CMD_SINGLE));
    op_short   = frame_data[7:0];
    op_long    = frame_data[31:24];
    addr       = frame_data[23:0];
  end

  // Command qualification
  always_comb begin
    can_cmd   = (state_q == sfe_pkg::SFE_IDLE) && !sleep_q;
    area_req  = can_cmd && is_long && latch_q &&
                (op_long == sfe_pkg::OP_SECTOR_ERASE ||
                 op_long == sfe_pkg::OP_HALF_ERASE ||
                 op_long == sfe_pkg::OP_BLOCK_ERASE);
    chip_req  = can_cmd && is_short && latch_q &&
                (op_short == sfe_pkg::OP_CHIP_ERASE_A ||
                 op_short == sfe_pkg::OP_CHIP_ERASE_B);
    chip_ok   = chip_req && (protect_bits == 4'h0) &&
                !block_lock_enable && !otp_mode;
    sleep_req = can_cmd && is_short && (op_short == sfe_pkg::OP_DEEP_SLEEP);
    arm_req   = can_cmd && is_short && (op_short == sfe_pkg::OP_WRITE_ARM);
    quad_req  = can_cmd && is_short && (op_short == sfe_pkg::OP_QUAD_ENTER);
    reset_req = is_short && (op_short == sfe_pkg::OP_SOFT_RESET) &&
                (state_q != sfe_pkg::SFE_ERASE);
    wake_req  = is_short && (op_short == sfe_pkg::OP_WAKE_ID) &&
                (sleep_q || state_q == sfe_pkg::SFE_SLEEP_WAIT);
  end

  // Erase unit from opcode
  always_comb begin
    if (op_long == sfe_pkg::OP_SECTOR_ERASE) begin
      area_kind = sfe_pkg::KIND_SECTOR;
      area_mask = sfe_pkg::MASK_SECTOR;
    end else if (op_long == sfe_pkg::OP_HALF_ERASE) begin
      area_kind = sfe_pkg::KIND_HALF;
      area_mask = sfe_pkg::MASK_HALF;
    end else begin
      area_kind = sfe_pkg::KIND_BLOCK;
      area_mask = sfe_pkg::MASK_BLOCK;
    end
  end

  // Protection check of the pending target
  always_comb begin
    check_ok = !region_locked;
    if (otp_mode) begin
      check_ok = check_ok && (kind_q == sfe_pkg::KIND_SECTOR) &&
                 (base_q[23:12] == sfe_pkg::OTP_SECTOR);
    end
  end

  // Self-timed length per erase kind
  always_comb begin
    case (kind_q)
      sfe_pkg::KIND_SECTOR: erase_len = SECTOR_ERASE_CYCLES;
      sfe_pkg::KIND_HALF:   erase_len = HALF_ERASE_CYCLES;
      sfe_pkg::KIND_BLOCK:  erase_len = BLOCK_ERASE_CYCLES;
      default:              erase_len = CHIP_ERASE_CYCLES;
    endcase
  end

  // Sequencer and cycle timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= sfe_pkg::SFE_IDLE;
      cnt_q   <= 32'h00000000;
    end else begin
      case (state_q)
        sfe_pkg::SFE_IDLE: begin
          if (area_req) begin
            state_q <= sfe_pkg::SFE_CHECK;
          end else if (chip_ok) begin
            state_q <= sfe_pkg::SFE_ERASE;
            cnt_q   <= CHIP_ERASE_CYCLES - 32'h00000001;
          end else if (sleep_req) begin
            state_q <= sfe_pkg::SFE_SLEEP_WAIT;
            cnt_q   <= sfe_pkg::SLEEP_ENTRY_CYCLES - 32'h00000001;
          end
        end
        sfe_pkg::SFE_CHECK: begin
          if (check_ok) begin
            state_q <= sfe_pkg::SFE_ERASE;
            cnt_q   <= erase_len - 32'h00000001;
          end else begin
            state_q <= sfe_pkg::SFE_IDLE;
          end
        end
        sfe_pkg::SFE_ERASE: begin
          if (cnt_q == 32'h00000000) begin
            state_q <= sfe_pkg::SFE_IDLE;
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        sfe_pkg::SFE_SLEEP_WAIT: begin
          if (wake_req || reset_req || cnt_q == 32'h00000000) begin
            state_q <= sfe_pkg::SFE_IDLE;
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        default: state_q <= sfe_pkg::SFE_IDLE;
      endcase
    end
  end

  // Deep power-down mode; power-up lands in standby
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_q <= 1'b0;
    end else if (wake_req || reset_req) begin
      sleep_q <= 1'b0;
    end else if (state_q == sfe_pkg::SFE_SLEEP_WAIT && cnt_q == 32'h00000000) begin
      sleep_q <= 1'b1;
    end
  end

  // Write latch: armed by command, dropped when an erase launches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else if (reset_req) begin
      latch_q <= 1'b0;
    end else if (arm_req) begin
      latch_q <= 1'b1;
    end else if (chip_ok || (state_q == sfe_pkg::SFE_CHECK && check_ok)) begin
      latch_q <= 1'b0;
    end
  end

  // Four-lane mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      quad_q <= 1'b0;
    end else if (reset_req) begin
      quad_q <= 1'b0;
    end else if (quad_req) begin
      quad_q <= 1'b1;
    end
  end

  // Erase target, start pulse to the array
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind_q  <= sfe_pkg::KIND_SECTOR;
      base_q  <= 24'h000000;
      start_q <= 1'b0;
    end else begin
      start_q <= chip_ok || (state_q == sfe_pkg::SFE_CHECK && check_ok);
      if (area_req) begin
        kind_q <= area_kind;
        base_q <= addr & area_mask;
      end else if (chip_ok) begin
        kind_q <= sfe_pkg::KIND_CHIP;
        base_q <= sfe_pkg::MASK_CHIP;
      end
    end
  end

  // Status snapshots, refreshed only while deselected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_hold_q  <= 8'h00;
      susp_hold_q  <= 8'h00;
      sleep_hold_q <= 1'b0;
    end else if (cs_s2_q && cs_s3_q) begin
      stat_hold_q                       <= 8'h00;
      stat_hold_q[sfe_pkg::ST_BUSY_BIT]  <= state_q == sfe_pkg::SFE_ERASE;
      stat_hold_q[sfe_pkg::ST_LATCH_BIT] <= latch_q;
      susp_hold_q                       <= 8'h00;
      susp_hold_q[sfe_pkg::ST_BUSY_BIT]  <= state_q == sfe_pkg::SFE_ERASE;
      susp_hold_q[sfe_pkg::SU_PSUS_BIT]  <= program_suspended_flag;
      susp_hold_q[sfe_pkg::SU_ESUS_BIT]  <= erase_suspended_flag;
      sleep_hold_q                      <= sleep_q;
    end
  end

  // Standby: settled deselect, idle, not asleep; moves with the busy snapshot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= cs_s2_q && cs_s3_q && (state_q == sfe_pkg::SFE_IDLE) && !sleep_q;
    end
  end

  // Frozen words toward the link
  assign lnk.stat_byte = stat_hold_q;
  assign lnk.susp_byte = susp_hold_q;
  assign lnk.quad      = quad_q;
  assign lnk.asleep    = sleep_hold_q;

  // Top-level outputs, all from flops
  assign busy_flag        = stat_hold_q[sfe_pkg::ST_BUSY_BIT];
  assign write_latch_flag = latch_q;
  assign deep_sleep       = sleep_q;
  assign quad_mode        = quad_q;
  assign standby          = standby_q;
  assign erase_start      = start_q;
  assign erase_kind       = kind_q;
  assign erase_base       = base_q;

endmodule
`default_nettype wire

// File: sim/sfe_core_asserts.sv
// Port-level assertions for the erase and power-down handler.
// Assumes one core clock domain; serial pins are not watched here.
`timescale 1ns/1ps
`default_nettype none
module sfe_core_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Protection inputs
  input wire logic [3:0]  protect_bits,
  input wire logic        block_lock_enable,
  input wire logic        otp_mode,
  // Status and erase outputs
  input wire logic        busy_flag,
  input wire logic        write_latch_flag,
  input wire logic        deep_sleep,
  input wire logic        standby,
  input wire logic        erase_start,
  input wire logic [1:0]  erase_kind,
  input wire logic [23:0] erase_base
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Launch, latch and busy relations
  start_pulse_a: assert property (erase_start |=> !erase_start)
    else $error("erase start longer than one cycle");
  latch_drop_a: assert property (erase_start |-> $past(write_latch_flag) && !write_latch_flag)
    else $error("erase launched without latch or latch kept");
  busy_rise_a: assert property (erase_start |-> ##[1:4] busy_flag)
    else $error("busy not raised after erase launch");
  // Protection and alignment
  chip_guard_a: assert property (erase_start && erase_kind == sfe_pkg::KIND_CHIP
    |-> protect_bits == 4'h0 && !block_lock_enable && !otp_mode)
    else $error("chip erase launched while protected");
  otp_guard_a: assert property (erase_start && otp_mode |-> erase_kind == sfe_pkg::KIND_SECTOR
    && erase_base[23:12] == sfe_pkg::OTP_SECTOR)
    else $error("erase outside the one-time sector in one-time mode");
  sector_align_a: assert property (erase_start |-> erase_base[11:0] == 12'h000)
    else $error("erase base not sector aligned");
  block_align_a: assert property (erase_start && erase_kind != sfe_pkg::KIND_SECTOR
    |-> erase_base[14:0] == 15'h0000)
    else $error("erase base not block aligned");
  // Power modes
  sleep_entry_a: assert property ($rose(deep_sleep) |-> !busy_flag)
    else $error("power-down entered while busy");
  asleep_quiet_a: assert property (deep_sleep |-> !erase_start && !standby)
    else $error("activity or standby while asleep");
  busy_standby_a: assert property (busy_flag |-> !standby)
    else $error("standby while a cycle runs");
endmodule
bind sfe_core sfe_core_asserts i_chk (
  .clk(clk), .rst_n(rst_n), .protect_bits(protect_bits),
  .block_lock_enable(block_lock_enable), .otp_mode(otp_mode), .busy_flag(busy_flag),
  .write_latch_flag(write_latch_flag), .deep_sleep(deep_sleep), .standby(standby),
  .erase_start(erase_start), .erase_kind(erase_kind), .erase_base(erase_base)
);
`default_nettype wire

// File: sim/sfe_host_model.sv
// Host serial controller model: frames commands with chip select.
// Assumes its tasks are called one at a time from a single process.
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
  // Serial pins
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] dq_i,
  input  wire logic [3:0] dq_o,
  input  wire logic [3:0] dq_oe
);
  logic [3:0] oe_seen;
  // Idle: deselected, clock still; select rises after time zero to clear the link
  initial begin
    sclk = 1'b0;
    dq_i = 4'hA;
    #1 cs_n = 1'b1;
  end
  // One command frame; data lines invert once released
  task automatic send(input logic [31:0] w, input int n, input bit quad);
    cs_n = 1'b0;
    #30;
    for (int i = 0; i < n; i++) begin
      dq_i = quad ? w[31:28] : {3'h0, w[31]};
      w = quad ? w << 4 : w << 1;
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #5 cs_n = 1'b1;
    dq_i = ~dq_i;
    #60;
  endtask
  // Single-lane status read, one byte after the opcode
  task automatic read_stat(input logic [7:0] op, output logic [7:0] v);
    v = 8'h00;
    cs_n = 1'b0;
    #30;
    for (int i = 0; i < 16; i++) begin
      dq_i = {3'h0, op[7]};
      op = op << 1;
      #15;
      if (i >= 8) v = {v[6:0], dq_o[1]};
      if (i == 8) oe_seen = dq_oe;
      sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #5 cs_n = 1'b1;
    dq_i = ~dq_i;
    #60;
  endtask
endmodule
`default_nettype wire

// File: sim/serial_flash_erase_powerdown_tb_top.sv
// Self-checking bench for the erase and power-down handler.
// Assumes the host model frames every command; core clock 100 MHz.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_powerdown_tb_top;
  logic        clk, rst_n, sclk, cs_n;
  logic [3:0]  dq_i, dq_o, dq_oe;
  logic [8:0]  ctl;
  logic        busy, latch, sleep, quad, stby, start;
  logic [1:0]  kind;
  logic [23:0] base;
  logic [31:0] lfsr_q;
  logic [25:0] seen_q[$];
  logic [7:0]  ops[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  logic [7:0]  wake[2] = '{8'hAB, 8'h99};
  logic [7:0]  s;
  int          bad_count, checked;
  bit          m_latch, m_sleep;

  sfe_host_model h (.sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  sfe_core #(.SECTOR_ERASE_CYCLES(200), .HALF_ERASE_CYCLES(200),
    .BLOCK_ERASE_CYCLES(200), .CHIP_ERASE_CYCLES(200)) i_dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .protect_bits(ctl[3:0]), .block_lock_enable(ctl[4]), .otp_mode(ctl[5]),
    .region_locked(ctl[6]), .program_suspended_flag(ctl[7]), .erase_suspended_flag(ctl[8]),
    .busy_flag(busy), .write_latch_flag(latch), .deep_sleep(sleep), .quad_mode(quad),
    .standby(stby), .erase_start(start), .erase_kind(kind), .erase_base(base));

  // Core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Record every launched erase
  always @(posedge clk) begin
    if (start === 1'b1) seen_q.push_back({kind, base});
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic setc(input logic [8:0] v);
    @(posedge clk);
    #1 ctl = v;
  endtask
  // Wait n clocks, then step off the edge before looking
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic arm(input bit q);
    h.send({sfe_pkg::OP_WRITE_ARM, 24'h0}, q ? 2 : 8, q);
    chk(32'(latch), 32'h1);
    m_latch = 1;
  endtask
  // Bounded poll until busy clears
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      h.read_stat(sfe_pkg::OP_READ_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 40);
    if (s[0] !== 1'b0) begin
      bad_count++;
      close_out();
    end
  endtask
  // Erase frame against the reference model
  task automatic erase(input logic [7:0] op, input bit q, input int cut);
    logic [23:0] a, m;
    logic [1:0]  k;
    bit          ok;
    lfsr_q = lfsr_next(lfsr_q);
    a = lfsr_q[23:0];
    if (ctl[5]) a[23:12] = sfe_pkg::OTP_SECTOR;
    k = op == 8'h20 ? 2'h0 : op == 8'h52 ? 2'h1 : op == 8'hD8 ? 2'h2 : 2'h3;
    m = k == 2'h0 ? 24'hFFF000 : k == 2'h1 ? 24'hFF8000 : k == 2'h2 ? 24'hFF0000 : 24'h0;
    ok = m_latch && cut == 0 && !m_sleep && !(k == 2'h3 && ctl[5:0] != 6'h00)
      && !(k != 2'h3 && ctl[6]) && !(ctl[5] && k != 2'h0);
    h.send({op, a}, (k == 2'h3 ? (q ? 2 : 8) : (q ? 8 : 32)) - cut, q);
    tick(10);
    chk(32'(seen_q.size()), 32'(ok));
    if (ok) begin
      chk(32'(seen_q.pop_front()), 32'({k, a & m}));
      chk(32'(latch), 32'h0);
      m_latch = 0;
      if (q) tick(250);
      else begin
        h.read_stat(sfe_pkg::OP_READ_SUSPEND, s);
        chk(32'(s[0]), 32'h1);
        wait_idle();
      end
      chk(32'(busy), 32'h0);
    end
  endtask

  initial begin
    ctl = 9'h000;
    rst_n = 1'b0;
    lfsr_q = 32'h703b;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(4);
    chk(32'(stby), 32'h1);
    h.read_stat(sfe_pkg::OP_READ_STATUS, s);
    chk(32'(s), 32'h0);
    chk(32'(h.oe_seen), 32'h2);
    chk(32'(dq_oe), 32'h0);
    foreach (ops[i]) begin
      arm(0);
      erase(ops[i], 0, 0);
    end
    $display("test accepted erases done");
    erase(8'h20, 0, 0);
    arm(0);
    erase(8'h20, 0, 1);
    erase(8'hC7, 0, 1);
    for (int i = 0; i < 5; i++) begin
      setc(9'h001 << (i + 2));
      erase(ops[(i + 1) % 5], 0, 0);
      arm(0);
    end
    setc(9'h020);
    erase(8'h20, 0, 0);
    arm(0);
    setc(9'h000);
    $display("test refusals done");
    for (int i = 1; i < 3; i++) begin
      setc(9'(i) << 7);
      h.read_stat(sfe_pkg::OP_READ_SUSPEND, s);
      chk(32'(s[3:2]), 32'(i));
    end
    h.send({8'hC7, 24'h0}, 8, 1'b0);
    tick(10);
    h.send({sfe_pkg::OP_DEEP_SLEEP, 24'h0}, 8, 1'b0);
    tick(320);
    chk(32'(sleep), 32'h0);
    chk(32'(seen_q.size()), 32'h1);
    seen_q.delete();
    foreach (wake[i]) begin
      arm(0);
      h.send({sfe_pkg::OP_DEEP_SLEEP, 24'h0}, 8, 1'b0);
      tick(310);
      chk(32'({sleep, stby}), 32'h2);
      m_sleep = 1;
      erase(8'h20, 0, 0);
      h.send({wake[i], 24'h0}, 8, 1'b0);
      chk(32'({sleep, stby}), 32'h1);
      m_sleep = 0;
    end
    $display("test power-down done");
    h.send({sfe_pkg::OP_QUAD_ENTER, 24'h0}, 8, 1'b0);
    chk(32'(quad), 32'h1);
    arm(1);
    erase(8'hD8, 1, 0);
    h.send({sfe_pkg::OP_SOFT_RESET, 24'h0}, 2, 1'b1);
    chk(32'(quad), 32'h0);
    $display("test quad done");
    close_out();
  end
endmodule
`default_nettype wire
